/* File: design/io_port_lane.v */
`timescale 1ns/100ps
// per-bit pin behaviour of one port
module io_port_lane #(
   parameter             WIDTH  = 8,
   parameter [WIDTH-1:0] BONDED = {WIDTH{1'b1}}
) (
   // register state
   input  wire [WIDTH-1:0] dir_i,
   input  wire [WIDTH-1:0] latch_i,
   input  wire [WIDTH-1:0] inhibit_i,
   // synchronised pin levels
   input  wire [WIDTH-1:0] pin_i,
   // read view and pin controls
   output wire [WIDTH-1:0] read_o,
   output wire [WIDTH-1:0] drive_o,
   output wire [WIDTH-1:0] oe_o,
   output wire [WIDTH-1:0] pulldown_o
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         // output buffer follows direction; low level when undriven
         assign oe_o[i]    = dir_i[i];                           // [R2]
         assign drive_o[i] = dir_i[i] & latch_i[i];              // [R2]
         if (BONDED[i]) begin : g_bonded
            // latch for outputs, pin for inputs
            assign read_o[i]     = dir_i[i] ? latch_i[i] : pin_i[i]; // [R3] [R5]
            assign pulldown_o[i] = ~dir_i[i] & ~inhibit_i[i];       // [R6]
         end else begin : g_unbonded
            // no pad: an input here is held low by its pulldown
            assign read_o[i]     = dir_i[i] ? latch_i[i] : 1'b0;    // [R10]
            assign pulldown_o[i] = ~dir_i[i];                       // [R10]
         end
      end
   endgenerate

endmodule // io_port_lane

/* File: design/parallel_io_ports.v */
`timescale 1ns/100ps
`include "parallel_io_ports_defines.vh"

// two parallel ports behind a classic wishbone slave
module parallel_io_ports #(
   parameter ADDR_W = 8
) (
   // clock and synchronous reset
   input  wire              clk_i,
   input  wire              rst_i,
   // wishbone classic slave
   input  wire              cyc_i,
   input  wire              stb_i,
   input  wire              we_i,
   input  wire [ADDR_W-1:0] adr_i,
   input  wire [3:0]        sel_i,
   input  wire [31:0]       dat_i,
   output wire [31:0]       dat_o,
   output wire              ack_o,
   // mask option strap
   input  wire              pulldown_inhibit_mask_option_i,
   // wide port pins
   input  wire [7:0]        wide_port_pin_i,
   output wire [7:0]        wide_port_pin_o,
   output wire [7:0]        wide_port_oe_o,
   output wire [7:0]        wide_port_pulldown_o,
   // narrow port pins (bonded bits 3 and 2)
   input  wire [1:0]        narrow_port_pin_i,
   output wire [1:0]        narrow_port_pin_o,
   output wire [1:0]        narrow_port_oe_o,
   output wire [1:0]        narrow_port_pulldown_o
);

   // register index decode, shared by read and write paths
   function hit;
      input [ADDR_W-1:0] adr;
      input [5:0]        idx;
      begin
         // upper address bits beyond the map must be zero
         hit = (adr[7:2] == idx) && ((adr >> 8) == {ADDR_W{1'b0}});
      end
   endfunction

   // full-width reset images, sliced on purpose for the narrow registers
   localparam [7:0] DIR_RST_FULL = `DIR_RESET & `NARROW_IMPL_MASK;
   localparam [7:0] INH_SET_FULL = `INHIBIT_OPTION_SET;
   localparam [7:0] INH_CLR_FULL = `INHIBIT_RESET;

   // register state
   reg  [7:0]  wide_port_data;
   reg  [5:0]  narrow_port_data;
   reg  [7:0]  wide_port_direction;
   reg  [5:0]  narrow_port_direction;
   reg  [7:0]  wide_pulldown_inhibit_bits;
   reg  [1:0]  narrow_pulldown_inhibit_bits;
   reg         option_seen;

   // bus state
   reg         ack;
   reg  [31:0] rd_data;
   reg  [7:0]  next_rd_byte;

   // synchronised inputs
   wire [10:0] sync_in;
   wire [7:0]  wide_pin_sync;
   wire [1:0]  narrow_pin_sync;
   wire        option_sync;

   // lane results
   wire [7:0]  wide_read;
   wire [5:0]  narrow_read;
   wire [5:0]  narrow_drive;
   wire [5:0]  narrow_oe;
   wire [5:0]  narrow_pulldown;
   wire [5:0]  narrow_pin_full;
   wire [5:0]  narrow_inhibit_full;

   // bus qualifiers
   wire        req;
   wire        wr_commit;
   wire        lane0;

   // every pin level and the strap cross into the clock domain first
   sync_two_flop #(
      .WIDTH (11)
   ) u_sync (
      .clk_i   (clk_i),
      .async_i ({pulldown_inhibit_mask_option_i,
                 narrow_port_pin_i,
                 wide_port_pin_i}),
      .sync_o  (sync_in)
   );

   assign wide_pin_sync   = sync_in[7:0];
   assign narrow_pin_sync = sync_in[9:8];
   assign option_sync     = sync_in[10];

   // bonded narrow pins sit at bits 3 and 2 of the six-bit lane
   assign narrow_pin_full = {2'b00, narrow_pin_sync, 2'b00};
   assign narrow_inhibit_full = {2'b00, narrow_pulldown_inhibit_bits, 2'b00};

   // wishbone request and its commit point
   assign req       = cyc_i & stb_i;
   assign lane0     = sel_i[0];
   // writes land on the edge where the master sees ack
   assign wr_commit = req & we_i & ack & lane0;

   // one-cycle ack, dropped the cycle after it was given
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack <= 1'b0;
      end else begin
         ack <= req & ~ack;
      end
   end

   // data latches carry no reset: contents survive reset
   always @(posedge clk_i) begin
      if (wr_commit && hit(adr_i, `WIDE_DATA_IDX)) begin
         // taken whatever the direction; inputs still read the pin
         wide_port_data <= dat_i[7:0];                     // [R4] [R12]
      end
      if (wr_commit && hit(adr_i, `NARROW_DATA_IDX)) begin
         // bits 7 and 6 do not exist
         narrow_port_data <= dat_i[5:0];                   // [R5] [R13] [R12]
      end
   end

   // direction registers: reset makes every pin an input
   always @(posedge clk_i) begin
      if (rst_i) begin
         wide_port_direction   <= `DIR_RESET;                  // [R12] [R9]
         narrow_port_direction <= DIR_RST_FULL[5:0];             // [R12] [R9]
      end else begin
         if (wr_commit && hit(adr_i, `WIDE_DIR_IDX)) begin
            wide_port_direction <= dat_i[7:0];                 // [R1]
         end
         if (wr_commit && hit(adr_i, `NARROW_DIR_IDX)) begin
            // unbonded bits stay writable; software keeps them 0
            narrow_port_direction <= dat_i[5:0];               // [R1] [R13] [R10]
         end
      end
   end

   // pulldown inhibit registers; reset value follows the strap
   always @(posedge clk_i) begin
      if (rst_i) begin
         if (option_sync) begin
            wide_pulldown_inhibit_bits   <= `INHIBIT_OPTION_SET;   // [R9]
            narrow_pulldown_inhibit_bits <=
               INH_SET_FULL[`NARROW_PIN_HI:`NARROW_PIN_LO];        // [R9]
         end else begin
            wide_pulldown_inhibit_bits   <= `INHIBIT_RESET;        // [R7]
            narrow_pulldown_inhibit_bits <=
               INH_CLR_FULL[`NARROW_PIN_HI:`NARROW_PIN_LO];        // [R8]
         end
      end else begin
         if (wr_commit && hit(adr_i, `WIDE_PULLDOWN_IDX)) begin
            wide_pulldown_inhibit_bits <= dat_i[7:0];             // [R6]
         end
         if (wr_commit && hit(adr_i, `NARROW_PULLDOWN_IDX)) begin
            // only bits 3 and 2 have an inhibit
            narrow_pulldown_inhibit_bits <=
               dat_i[`NARROW_PIN_HI:`NARROW_PIN_LO];              // [R8]
         end
      end
   end

   // strap value seen at the last reset, for software to read
   always @(posedge clk_i) begin
      if (rst_i) begin
         option_seen <= option_sync;
      end
   end

   // wide port pin behaviour
   io_port_lane #(
      .WIDTH  (8),
      .BONDED (8'hFF)
   ) u_wide_lane (
      .dir_i      (wide_port_direction),
      .latch_i    (wide_port_data),
      .inhibit_i  (wide_pulldown_inhibit_bits),
      .pin_i      (wide_pin_sync),
      .read_o     (wide_read),
      .drive_o    (wide_port_pin_o),
      .oe_o       (wide_port_oe_o),
      .pulldown_o (wide_port_pulldown_o)
   );

   // narrow port: six bits, only bits 3 and 2 reach pads
   io_port_lane #(
      .WIDTH  (6),
      .BONDED (`NARROW_BONDED_MASK)
   ) u_narrow_lane (
      .dir_i      (narrow_port_direction),
      .latch_i    (narrow_port_data),
      .inhibit_i  (narrow_inhibit_full),
      .pin_i      (narrow_pin_full),
      .read_o     (narrow_read),
      .drive_o    (narrow_drive),
      .oe_o       (narrow_oe),
      .pulldown_o (narrow_pulldown)
   );

   // bonded narrow bits out to the pads
   assign narrow_port_pin_o      = narrow_drive[`NARROW_PIN_HI:`NARROW_PIN_LO]; // [R5]
   assign narrow_port_oe_o       = narrow_oe[`NARROW_PIN_HI:`NARROW_PIN_LO];    // [R2]
   assign narrow_port_pulldown_o =
      narrow_pulldown[`NARROW_PIN_HI:`NARROW_PIN_LO];                           // [R8]

   // read mux; inhibit registers are write-only and read zero
   always @* begin
      next_rd_byte = 8'h00;
      if (hit(adr_i, `WIDE_DATA_IDX)) begin
         next_rd_byte = wide_read;                              // [R3]
      end else if (hit(adr_i, `NARROW_DATA_IDX)) begin
         next_rd_byte = {2'b00, narrow_read};                   // [R5] [R13]
      end else if (hit(adr_i, `WIDE_DIR_IDX)) begin
         next_rd_byte = wide_port_direction;
      end else if (hit(adr_i, `NARROW_DIR_IDX)) begin
         next_rd_byte = {2'b00, narrow_port_direction};         // [R13]
      end else if (hit(adr_i, `OPTION_STATUS_IDX)) begin
         next_rd_byte[`OPTION_STATUS_BIT] = option_seen;
      end
   end

   // read data is captured as ack rises and held with it
   always @(posedge clk_i) begin
      if (rst_i) begin
         rd_data <= 32'h0000_0000;
      end else if (req && !ack) begin
         rd_data <= {24'h00_0000, next_rd_byte};
      end
   end

   assign dat_o = rd_data;
   assign ack_o = ack;

endmodule // parallel_io_ports

/* File: design/parallel_io_ports_defines.vh */
// Functional notes
// R1: ten two-way pins, one 8-bit and one 2-bit port, each pin's direction set alone.
// R2: direction 1 drives the latched value out; direction 0 leaves the pin undriven.
// R3: wide data read gives latch for output bits, pin level for input bits.
// R4: data latches take every write; writes never change what an input pin reads.
// R5: narrow port reads and writes behave exactly like the wide port; the code reads bits 7 and 6, and unbonded input bits, as zero.
// R6: each wide input pin has a pulldown; inhibit bit 1 disables, 0 enables.
// R7: reset clears all eight wide inhibit bits unless the mask option overrides.
// R8: narrow inhibit bits sit at 3 and 2; 1 disables; reset clears both; the code sets both instead when the mask option is 1.
// R9: mask option 1 makes reset leave every pin input with pulldown disabled.
// R10: unbonded narrow bits 5,4,1,0 stay read/write; pulldown always on as input.
// R11: software keeps the unbonded narrow bits as inputs at all times.
// R12: reset clears every direction bit; both data latches keep their contents.
// R13: narrow data and direction bits 7 and 6 read zero and ignore writes.
`ifndef PARALLEL_IO_PORTS_DEFINES_VH
`define PARALLEL_IO_PORTS_DEFINES_VH

// register indices; byte address is four times the index
`define WIDE_DATA_IDX       6'h00
`define NARROW_DATA_IDX     6'h01
`define WIDE_DIR_IDX        6'h04
`define NARROW_DIR_IDX      6'h05
`define WIDE_PULLDOWN_IDX   6'h10
`define NARROW_PULLDOWN_IDX 6'h11
`define OPTION_STATUS_IDX   6'h20

// reset values
`define DIR_RESET           8'h00
`define INHIBIT_RESET       8'h00
`define INHIBIT_OPTION_SET  8'hFF

// narrow port field layout
`define NARROW_IMPL_MASK    8'h3F
`define NARROW_BONDED_MASK  6'h0C
`define NARROW_INHIBIT_MASK 8'h0C
`define NARROW_PIN_LO       2
`define NARROW_PIN_HI       3

// option status field position
`define OPTION_STATUS_BIT   0

`endif

/* File: design/sync_two_flop.v */
`timescale 1ns/100ps
// two-flop synchroniser for levels from outside the clock domain
module sync_two_flop #(
   parameter WIDTH = 1
) (
   // clock
   input  wire             clk_i,
   // asynchronous level in, synchronised level out
   input  wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);

   reg [WIDTH-1:0] meta;
   reg [WIDTH-1:0] stable;

   // first stage feeds only the second stage
   always @(posedge clk_i) begin
      meta   <= async_i;
      stable <= meta;
   end

   assign sync_o = stable;

endmodule // sync_two_flop

/* File: tb/parallel_io_ports_props.sv */
`timescale 1ns/100ps
// bus timing and pin outputs seen from the block's ports
module parallel_io_ports_props #(
   parameter ADDR_W = 8
) (
   // clock, reset and bus
   input wire              clk_i,
   input wire              rst_i,
   input wire              cyc_i,
   input wire              stb_i,
   input wire              we_i,
   input wire [ADDR_W-1:0] adr_i,
   input wire [3:0]        sel_i,
   input wire [31:0]       dat_i,
   input wire [31:0]       dat_o,
   input wire              ack_o,
   // strap and pins
   input wire              pulldown_inhibit_mask_option_i,
   input wire [7:0]        wide_port_pin_o,
   input wire [7:0]        wide_port_oe_o,
   input wire [7:0]        wide_port_pulldown_o,
   input wire [1:0]        narrow_port_oe_o,
   input wire [1:0]        narrow_port_pulldown_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // fresh request, and the commit edge of a wide direction write
   sequence s_req; cyc_i && stb_i && !ack_o; endsequence
   sequence s_wdir; ack_o && we_i && sel_i[0] && adr_i[7:2] == 6'h04; endsequence
   AST_ACK_NEXT: assert property (s_req |=> ack_o)
      else $error("no ack after request");
   AST_ACK_DROP: assert property (ack_o |=> !ack_o)
      else $error("ack held");
   AST_WIDE_OE: assert property (s_wdir |=> wide_port_oe_o == $past(dat_i[7:0]))
      else $error("direction write not on oe");
   AST_UNDRIVEN: assert property ((wide_port_pin_o & ~wide_port_oe_o) == 8'h00)
      else $error("drive value on input pin");
   AST_PD_INPUT: assert property ((wide_port_pulldown_o & wide_port_oe_o) == 8'h00)
      else $error("pulldown on output pin");
   AST_RST_DIR: assert property ($fell(rst_i) |-> !wide_port_oe_o && !narrow_port_oe_o)
      else $error("pin driven after reset");
   AST_RST_PD: assert property ($fell(rst_i) |->
      wide_port_pulldown_o == {8{!pulldown_inhibit_mask_option_i}} &&
      narrow_port_pulldown_o == {2{!pulldown_inhibit_mask_option_i}})
      else $error("pulldowns wrong after reset");
   AST_HIGH_ZERO: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h0)
      else $error("read upper bits not zero");
endmodule // parallel_io_ports_props

/* File: tb/parallel_io_ports_tb_top.sv */
`timescale 1ns/100ps
// table of register transfers, then pulldown, reset and strap cases
module parallel_io_ports_tb_top;
   localparam ADDR_W = 8;
   logic        clk_i = 1'h0;
   logic        rst_i = 1'h1;
   logic        cyc_i = 1'h0;
   logic        stb_i = 1'h0;
   logic        we_i = 1'h0;
   logic [7:0]  adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0;
   logic        strap = 1'h0;
   logic [3:0]  sel = 4'hF;
   logic [7:0]  wben = 8'hFF;
   logic [31:0] q;
   wire  [31:0] dat_o;
   wire         ack_o;
   wire  [7:0]  wpin, wdrv, woe, wpd;
   wire  [1:0]  npin, ndrv, noe, npd;
   int          fails = 0;
   int          n_compared = 0;
   // write flag, address, data, expected read byte; unbonded kept input
   logic [24:0] rows [12] = '{{1'h1,8'h10,8'h0F,8'h00}, {1'h1,8'h00,8'h3C,8'h00},
      {1'h0,8'h00,8'h00,8'hAC}, {1'h0,8'h10,8'h00,8'h0F}, {1'h1,8'h14,8'hCC,8'h00},
      {1'h1,8'h04,8'hFF,8'h00}, {1'h0,8'h14,8'h00,8'h0C}, {1'h0,8'h04,8'h00,8'h0C},
      {1'h1,8'h14,8'h00,8'h00}, {1'h0,8'h04,8'h00,8'h08}, {1'h0,8'h40,8'h00,8'h00},
      {1'h0,8'h0C,8'h00,8'h00}};
   always #20 clk_i = ~clk_i;
   parallel_io_ports #(.ADDR_W(ADDR_W)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pulldown_inhibit_mask_option_i(strap),
      .wide_port_pin_i(wpin), .wide_port_pin_o(wdrv), .wide_port_oe_o(woe),
      .wide_port_pulldown_o(wpd), .narrow_port_pin_i(npin), .narrow_port_pin_o(ndrv),
      .narrow_port_oe_o(noe), .narrow_port_pulldown_o(npd));
   pin_board_model #(.W(8)) wide_u (.clk_i(clk_i), .oe_i(woe), .drive_i(wdrv),
      .pulldown_i(wpd), .board_en_i(wben), .board_val_i(8'hA5), .level_o(wpin));
   pin_board_model #(.W(2)) narrow_u (.clk_i(clk_i), .oe_i(noe), .drive_i(ndrv),
      .pulldown_i(npd), .board_en_i(2'h3), .board_val_i(2'h2), .level_o(npin));
   // one classic cycle; idle edges let pin levels pass the synchroniser
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'h1;
      stb_i <= 1'h1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h0, d};
      // look at ack mid-cycle, then take data at the edge that samples it
      @(negedge clk_i);
      while (ack_o !== 1'h1 && n < 20) begin
         @(negedge clk_i);
         n++;
      end
      if (n == 20) begin
         fails++;
         $display("BAD %0t no ack", $time);
      end
      @(posedge clk_i);
      q = dat_o;
      cyc_i <= 1'h0;
      stb_i <= 1'h0;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // four edges so the strap settles before it is caught
   task automatic do_reset(input logic s);
      @(posedge clk_i);
      rst_i <= 1'h1;
      strap <= s;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'h0;
      @(posedge clk_i);
      @(negedge clk_i);
   endtask
   task give_verdict;
      $display("compared %0d mismatched %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      do_reset(1'h0);
      foreach (rows[i]) begin
         xfer(rows[i][24], rows[i][23:16], rows[i][15:8]);
         if (!rows[i][24]) chk(q[7:0], rows[i][7:0]);
      end
      $display("table done");
      chk(woe, 8'h0F);
      chk(wdrv, 8'h0C);
      chk(wpd, 8'hF0);
      xfer(1'h1, 8'h40, 8'hF0);
      xfer(1'h1, 8'h44, 8'h04);
      chk(wpd, 8'h00);
      chk({6'h0, npd}, 8'h02);
      $display("pulldown done");
      do_reset(1'h0);
      chk(woe, 8'h00);
      chk(wpd, 8'hFF);
      chk({6'h0, npd}, 8'h03);
      // board lets go: only the pulldowns hold the inputs low
      @(posedge clk_i);
      wben <= 8'h00;
      repeat (3) @(posedge clk_i);
      xfer(1'h0, 8'h00, 8'h00);
      chk(q[7:0], 8'h00);
      @(posedge clk_i);
      wben <= 8'hFF;
      sel <= 4'hE;
      // a write without byte lane 0 is acked and ignored
      xfer(1'h1, 8'h10, 8'hFF);
      @(posedge clk_i);
      sel <= 4'hF;
      xfer(1'h0, 8'h10, 8'h00);
      chk(q[7:0], 8'h00);
      xfer(1'h1, 8'h10, 8'hFF);
      xfer(1'h0, 8'h00, 8'h00);
      chk(q[7:0], 8'h3C);
      do_reset(1'h1);
      chk(woe, 8'h00);
      chk(wpd | {6'h0, npd}, 8'h00);
      xfer(1'h0, 8'h80, 8'h00);
      chk(q[7:0], 8'h01);
      $display("reset cases done");
      give_verdict;
   end
   // about one hundred and fifty cycles of traffic; this span is far beyond it
   initial begin
      #40000;
      fails++;
      give_verdict;
   end
endmodule // parallel_io_ports_tb_top

bind parallel_io_ports parallel_io_ports_props #(.ADDR_W(ADDR_W)) props_u (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
   .pulldown_inhibit_mask_option_i(pulldown_inhibit_mask_option_i),
   .wide_port_pin_o(wide_port_pin_o), .wide_port_oe_o(wide_port_oe_o),
   .wide_port_pulldown_o(wide_port_pulldown_o), .narrow_port_oe_o(narrow_port_oe_o),
   .narrow_port_pulldown_o(narrow_port_pulldown_o));

/* File: tb/pin_board_model.sv */
`timescale 1ns/100ps
// board logic on one port: drives the pins the block leaves free
module pin_board_model #(
   parameter W = 8
) (
   // clock of the drift pattern
   input  wire         clk_i,
   // block side of each pin
   input  wire [W-1:0] oe_i,
   input  wire [W-1:0] drive_i,
   input  wire [W-1:0] pulldown_i,
   // board drivers and resolved level
   input  wire [W-1:0] board_en_i,
   input  wire [W-1:0] board_val_i,
   output wire [W-1:0] level_o
);
   reg [W-1:0] drift = {W{1'h0}};
   // floating pins toggle so a lost pulldown cannot pass for 0
   always @(posedge clk_i) begin
      drift <= ~drift;
   end
   // block drive wins, then board, then pulldown or drift
   assign level_o = (oe_i & drive_i) | (~oe_i & board_en_i & board_val_i)
                  | (~oe_i & ~board_en_i & ~pulldown_i & drift);
endmodule // pin_board_model
